/* File: design/spcc_top.sv */
`timescale 1ns/1ps
// Connect-status control of a multidrop addressable scan port.
module spcc_top
  import spcc_pkg::*;
(
  input  wire logic              MCLK_I,
  input  wire logic              RSTN_I,
  input  wire logic              UPSTREAM_TEST_CLOCK_I,
  input  wire logic              UPSTREAM_DATA_IN_I,
  input  wire logic              UPSTREAM_MODE_SELECT_I,
  input  wire logic              UPSTREAM_TEST_RESET_N_I,
  input  wire logic              DOWNSTREAM_DATA_IN_I,
  input  wire logic              FORCE_THROUGH_N_I,
  input  wire logic [ADDR_W-1:0] BOARD_ADDRESS_PINS_I,
  output logic                   UPSTREAM_DATA_OUT_O,
  output logic                   UPSTREAM_DATA_OUT_OE_O,
  output logic                   DOWNSTREAM_DATA_OUT_O,
  output logic                   DOWNSTREAM_DATA_OUT_OE_O,
  output logic                   DOWNSTREAM_MODE_SELECT_O,
  output logic                   DOWNSTREAM_TEST_CLOCK_O,
  output logic                   DOWNSTREAM_TEST_RESET_N_O,
  output logic                   LINK_ACTIVE_N_O
);

  spcc_pins_t        pin_raw;
  spcc_pins_t        pin_s1_ff;
  spcc_pins_t        pin_s2_ff;
  logic [ADDR_W-1:0] addr_s1_ff;
  logic [ADDR_W-1:0] addr_s2_ff;
  logic              tck_d_ff;
  logic              rise;
  logic              fall;
  logic              byp_low;
  logic              trst_low;
  logic              rx_hold;
  spcc_tap_t         ptap;
  spcc_tap_t         stap;
  logic              accept;
  logic              both_pause;
  spcc_rx_t          rx_st_ff;
  logic [3:0]        rx_cnt_ff;
  logic [ADDR_W-1:0] rx_sh_ff;
  logic              rx_tms_ff;
  logic [ADDR_W-1:0] rx_word;
  logic              push_valid;
  logic              push_ready;
  logic              pop_valid;
  logic              pop_ready;
  logic [ADDR_W-1:0] pop_word;
  logic              pop;
  logic              hard_err;
  spcc_conn_t        status_ff;
  logic [3:0]        ack_cnt_ff;
  logic [ADDR_W-1:0] ack_sh_ff;
  logic              ack_tms_ff;
  logic              ack_done;
  spcc_drive_t       drv_ff;

  assign pin_raw = '{tck:    UPSTREAM_TEST_CLOCK_I,
                     tdi:    UPSTREAM_DATA_IN_I,
                     tms:    UPSTREAM_MODE_SELECT_I,
                     trst_n: UPSTREAM_TEST_RESET_N_I,
                     sdi:    DOWNSTREAM_DATA_IN_I,
                     byp_n:  FORCE_THROUGH_N_I};

  // Every pin crosses two flops before any decision reads it.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pin_s1_ff  <= '{tck: 1'b0, tdi: 1'b1, tms: 1'b1, trst_n: 1'b0,
                      sdi: 1'b1, byp_n: 1'b1};
      pin_s2_ff  <= '{tck: 1'b0, tdi: 1'b1, tms: 1'b1, trst_n: 1'b0,
                      sdi: 1'b1, byp_n: 1'b1};
      addr_s1_ff <= '0;
      addr_s2_ff <= '0;
    end else begin
      pin_s1_ff  <= pin_raw;
      pin_s2_ff  <= pin_s1_ff;
      addr_s1_ff <= BOARD_ADDRESS_PINS_I;
      addr_s2_ff <= addr_s1_ff;
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tck_d_ff <= 1'b0;
    end else begin
      tck_d_ff <= pin_s2_ff.tck;
    end
  end

  assign rise     = pin_s2_ff.tck & ~tck_d_ff;
  assign fall     = ~pin_s2_ff.tck & tck_d_ff;
  assign byp_low  = ~pin_s2_ff.byp_n;
  assign trst_low = ~pin_s2_ff.trst_n;
  assign rx_hold  = byp_low | trst_low;

  // Test reset is a plain wire from pin to pin.
  assign DOWNSTREAM_TEST_RESET_N_O = UPSTREAM_TEST_RESET_N_I;

  spcc_tap_track u_ptap (
    .clk_i   (MCLK_I),
    .rst_n_i (RSTN_I),
    .clr_i   (trst_low),
    .adv_i   (rise),
    .tms_i   (pin_s2_ff.tms),
    .state_o (ptap)
  );

  // The secondary chain sees the mode select this block drives.
  spcc_tap_track u_stap (
    .clk_i   (MCLK_I),
    .rst_n_i (RSTN_I),
    .clr_i   (trst_low),
    .adv_i   (rise),
    .tms_i   (drv_ff.downstream_mode_select),
    .state_o (stap)
  );

  assign accept = (ptap == TAP_TLR) || (ptap == TAP_RTI) ||
                  (ptap == TAP_PDR) || (ptap == TAP_PIR);
  assign both_pause = ((ptap == TAP_PDR) || (ptap == TAP_PIR)) &&
                      ((stap == TAP_PDR) || (stap == TAP_PIR));

  // Receiver: start bit low, then ten address bits, first bit lowest.
  assign rx_word    = {pin_s2_ff.tdi, rx_sh_ff[ADDR_W-1:1]};
  assign push_valid = rise && !rx_hold && (rx_st_ff == RX_ADDR) &&
                      (rx_cnt_ff == ADDR_LAST) &&
                      (pin_s2_ff.tms == rx_tms_ff);

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_st_ff  <= RX_IDLE;
      rx_cnt_ff <= '0;
      rx_sh_ff  <= '0;
      rx_tms_ff <= 1'b0;
    end else if (rx_hold) begin
      rx_st_ff  <= RX_IDLE;
      rx_cnt_ff <= '0;
    end else if (rise) begin
      case (rx_st_ff)
        RX_IDLE: begin
          if (accept && !pin_s2_ff.tdi && push_ready &&
              status_ff != CS_ACK) begin
            rx_st_ff  <= RX_ADDR;
            rx_cnt_ff <= '0;
            rx_tms_ff <= pin_s2_ff.tms;
          end
        end
        RX_ADDR: begin
          if (pin_s2_ff.tms != rx_tms_ff) begin
            rx_st_ff <= RX_IDLE;
          end else begin
            rx_sh_ff  <= rx_word;
            rx_cnt_ff <= rx_cnt_ff + 1'b1;
            if (rx_cnt_ff == ADDR_LAST) begin
              rx_st_ff <= RX_IDLE;
            end
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  spcc_fifo #(
    .W     (ADDR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (MCLK_I),
    .rst_n_i     (RSTN_I),
    .flush_i     (rx_hold),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (rx_word),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_word)
  );

  assign pop_ready = !rx_hold && (status_ff != CS_ACK);
  assign pop       = pop_valid && pop_ready;
  assign hard_err  = rise && !rx_hold &&
                     (((rx_st_ff == RX_ADDR) &&
                       (pin_s2_ff.tms != rx_tms_ff)) ||
                      ((status_ff == CS_ACK) &&
                       (pin_s2_ff.tms != ack_tms_ff)));
  assign ack_done  = fall && !rx_hold && (status_ff == CS_ACK) &&
                     (ack_cnt_ff == ACK_LAST);

  // Status survives bypass untouched unless test reset is low, so release restores it.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      status_ff <= CS_OFF;
    end else if (trst_low) begin
      status_ff <= CS_OFF;
    end else if (hard_err) begin
      status_ff <= CS_OFF;
    end else if (pop) begin
      if (pop_word == ADDR_RESTART) begin
        status_ff <= CS_RESET;
      end else if (pop_word == ADDR_DROP) begin
        status_ff <= CS_OFF;
      end else if (pop_word == ADDR_SYNC) begin
        status_ff <= both_pause ? CS_MCAST : CS_OFF;
      end else if (pop_word == addr_s2_ff) begin
        status_ff <= CS_ACK;
      end else begin
        status_ff <= CS_OFF;
      end
    end else if (ack_done) begin
      status_ff <= CS_ON;
    end
  end

  // Acknowledge returns the board address on falling clock edges.
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ack_cnt_ff <= '0;
      ack_sh_ff  <= '0;
      ack_tms_ff <= 1'b0;
    end else if (pop) begin
      ack_cnt_ff <= '0;
      ack_sh_ff  <= addr_s2_ff;
      ack_tms_ff <= pin_s2_ff.tms;
    end else if (fall && !rx_hold && status_ff == CS_ACK) begin
      ack_cnt_ff <= ack_cnt_ff + 1'b1;
      ack_sh_ff  <= {1'b0, ack_sh_ff[ADDR_W-1:1]};
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      drv_ff <= '{downstream_test_clock: 1'b0, downstream_data_out: 1'b0, downstream_data_out_oe: 1'b0, upstream_data_out: 1'b0,
                  upstream_data_out_oe: 1'b0, downstream_mode_select: RST_DOWNSTREAM_MODE_SELECT, link_n: RST_LINK_N};
    end else begin
      drv_ff.downstream_test_clock <= pin_s2_ff.tck;
      if (byp_low) begin
        drv_ff.downstream_data_out    <= pin_s2_ff.tdi;
        drv_ff.downstream_data_out_oe <= 1'b1;
        drv_ff.upstream_data_out    <= pin_s2_ff.sdi;
        drv_ff.upstream_data_out_oe <= 1'b1;
        drv_ff.downstream_mode_select    <= trst_low ? 1'b1 : pin_s2_ff.tms;
        drv_ff.link_n  <= 1'b0;
      end else if (trst_low) begin
        drv_ff.downstream_data_out_oe <= 1'b0;
        drv_ff.upstream_data_out_oe <= 1'b0;
        drv_ff.downstream_mode_select    <= 1'b1;
        drv_ff.link_n  <= 1'b1;
      end else begin
        case (status_ff)
          CS_ON: begin
            drv_ff.downstream_data_out    <= pin_s2_ff.tdi;
            drv_ff.downstream_data_out_oe <= 1'b1;
            drv_ff.upstream_data_out    <= pin_s2_ff.sdi;
            drv_ff.upstream_data_out_oe <= 1'b1;
            drv_ff.downstream_mode_select    <= pin_s2_ff.tms;
            drv_ff.link_n  <= 1'b0;
          end
          CS_MCAST: begin
            drv_ff.downstream_data_out    <= pin_s2_ff.tdi;
            drv_ff.downstream_data_out_oe <= 1'b1;
            drv_ff.upstream_data_out_oe <= 1'b0;
            drv_ff.downstream_mode_select    <= pin_s2_ff.tms;
            drv_ff.link_n  <= 1'b0;
          end
          CS_RESET: begin
            drv_ff.downstream_data_out_oe <= 1'b0;
            drv_ff.upstream_data_out_oe <= 1'b0;
            drv_ff.downstream_mode_select    <= 1'b1;
            drv_ff.link_n  <= 1'b1;
          end
          CS_ACK: begin
            drv_ff.upstream_data_out    <= ack_sh_ff[0];
            drv_ff.upstream_data_out_oe <= 1'b1;
            drv_ff.downstream_data_out_oe <= 1'b0;
            drv_ff.link_n  <= 1'b1;
          end
          default: begin
            drv_ff.downstream_data_out_oe <= 1'b0;
            drv_ff.upstream_data_out_oe <= 1'b0;
            drv_ff.link_n  <= 1'b1;
          end
        endcase
      end
    end
  end

  assign UPSTREAM_DATA_OUT_O      = drv_ff.upstream_data_out;
  assign UPSTREAM_DATA_OUT_OE_O   = drv_ff.upstream_data_out_oe;
  assign DOWNSTREAM_DATA_OUT_O    = drv_ff.downstream_data_out;
  assign DOWNSTREAM_DATA_OUT_OE_O = drv_ff.downstream_data_out_oe;
  assign DOWNSTREAM_MODE_SELECT_O = drv_ff.downstream_mode_select;
  assign DOWNSTREAM_TEST_CLOCK_O  = drv_ff.downstream_test_clock;
  assign LINK_ACTIVE_N_O          = drv_ff.link_n;

  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);

  sequence seq_match_pop;
    pop && !rx_hold && !hard_err && pop_word == addr_s2_ff &&
    pop_word != ADDR_RESTART && pop_word != ADDR_DROP &&
    pop_word != ADDR_SYNC;
  endsequence

  sequence seq_ack_done;
    ack_done && !trst_low && !hard_err;
  endsequence

  a_drop_goes_off: assert property (
    pop && !trst_low && !hard_err && pop_word == ADDR_DROP |=>
      status_ff == CS_OFF ##1 !UPSTREAM_DATA_OUT_OE_O || byp_low)
    else $error("drop address did not give off status");

  a_restart_mode_high: assert property (
    pop && !trst_low && !hard_err && pop_word == ADDR_RESTART
      ##1 !byp_low |=> DOWNSTREAM_MODE_SELECT_O)
    else $error("restart address did not force mode select high");

  a_sync_gate_pause: assert property (
    pop && !trst_low && !hard_err && pop_word == ADDR_SYNC |=>
      (status_ff == CS_MCAST) == $past(both_pause))
    else $error("group sync outcome disagrees with pause states");

  a_bypass_link_low: assert property (
    byp_low |=> !LINK_ACTIVE_N_O && DOWNSTREAM_DATA_OUT_OE_O)
    else $error("bypass did not drive link active low");

  a_bypass_data_path: assert property (
    byp_low |=> DOWNSTREAM_DATA_OUT_O == $past(pin_s2_ff.tdi) &&
      UPSTREAM_DATA_OUT_O == $past(pin_s2_ff.sdi))
    else $error("bypass data path not routed");

  a_hold_rx_idle: assert property (
    rx_hold |=> rx_st_ff == RX_IDLE && !pop_valid)
    else $error("receiver not held in idle during bypass or reset");

  a_trst_downstream_mode_select_high: assert property (
    trst_low |=> DOWNSTREAM_MODE_SELECT_O [*1])
    else $error("mode select not high during test reset");

  a_trst_hold_float: assert property (
    trst_low && !byp_low |=> LINK_ACTIVE_N_O &&
      !UPSTREAM_DATA_OUT_OE_O && !DOWNSTREAM_DATA_OUT_OE_O)
    else $error("reset hold status not applied");

  a_match_then_ack: assert property (
    seq_match_pop |=> status_ff == CS_ACK ##1
      (LINK_ACTIVE_N_O || byp_low))
    else $error("match did not start an acknowledge");

  a_ack_then_on: assert property (
    seq_ack_done |=> status_ff == CS_ON ##1
      (!LINK_ACTIVE_N_O || byp_low))
    else $error("acknowledge end did not connect the port");

  a_hard_err_off: assert property (
    hard_err && !trst_low |=> status_ff == CS_OFF)
    else $error("mode select change not treated as hard error");

endmodule

/* File: design/spcc_pkg.sv */
package spcc_pkg;

  localparam int          ADDR_W       = 10;
  localparam int          FIFO_DEPTH   = 2;
  localparam logic [9:0]  ADDR_RESTART = 10'h000;
  localparam logic [9:0]  ADDR_DROP    = 10'h3FE;
  localparam logic [9:0]  ADDR_SYNC    = 10'h3FF;
  localparam logic [3:0]  ADDR_LAST    = 4'h9;
  localparam logic [3:0]  ACK_LAST     = 4'h9;
  localparam logic        RST_DOWNSTREAM_MODE_SELECT     = 1'b1;
  localparam logic        RST_LINK_N   = 1'b1;

  typedef enum logic [3:0] {
    TAP_TLR, TAP_RTI, TAP_SDR, TAP_CDR, TAP_SHDR, TAP_E1DR, TAP_PDR,
    TAP_E2DR, TAP_UDR, TAP_SIR, TAP_CIR, TAP_SHIR, TAP_E1IR, TAP_PIR,
    TAP_E2IR, TAP_UIR
  } spcc_tap_t;

  typedef enum logic [2:0] {
    CS_OFF, CS_ON, CS_RESET, CS_MCAST, CS_ACK
  } spcc_conn_t;

  typedef enum logic [0:0] {RX_IDLE, RX_ADDR} spcc_rx_t;

  typedef struct packed {
    logic tck;
    logic tdi;
    logic tms;
    logic trst_n;
    logic sdi;
    logic byp_n;
  } spcc_pins_t;

  typedef struct packed {
    logic downstream_test_clock;
    logic downstream_data_out;
    logic downstream_data_out_oe;
    logic upstream_data_out;
    logic upstream_data_out_oe;
    logic downstream_mode_select;
    logic link_n;
  } spcc_drive_t;

endpackage

/* File: design/spcc_tap_track.sv */
`timescale 1ns/1ps
// Follows a TAP controller state from the mode select seen at each rise.
module spcc_tap_track
  import spcc_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_n_i,
  input  wire logic      clr_i,
  input  wire logic      adv_i,
  input  wire logic      tms_i,
  output spcc_tap_t      state_o
);

  spcc_tap_t state_ff;
  spcc_tap_t nxt_state;

  always_comb begin
    case (state_ff)
      TAP_TLR:  nxt_state = tms_i ? TAP_TLR  : TAP_RTI;
      TAP_RTI:  nxt_state = tms_i ? TAP_SDR  : TAP_RTI;
      TAP_SDR:  nxt_state = tms_i ? TAP_SIR  : TAP_CDR;
      TAP_CDR:  nxt_state = tms_i ? TAP_E1DR : TAP_SHDR;
      TAP_SHDR: nxt_state = tms_i ? TAP_E1DR : TAP_SHDR;
      TAP_E1DR: nxt_state = tms_i ? TAP_UDR  : TAP_PDR;
      TAP_PDR:  nxt_state = tms_i ? TAP_E2DR : TAP_PDR;
      TAP_E2DR: nxt_state = tms_i ? TAP_UDR  : TAP_SHDR;
      TAP_UDR:  nxt_state = tms_i ? TAP_SDR  : TAP_RTI;
      TAP_SIR:  nxt_state = tms_i ? TAP_TLR  : TAP_CIR;
      TAP_CIR:  nxt_state = tms_i ? TAP_E1IR : TAP_SHIR;
      TAP_SHIR: nxt_state = tms_i ? TAP_E1IR : TAP_SHIR;
      TAP_E1IR: nxt_state = tms_i ? TAP_UIR  : TAP_PIR;
      TAP_PIR:  nxt_state = tms_i ? TAP_E2IR : TAP_PIR;
      TAP_E2IR: nxt_state = tms_i ? TAP_UIR  : TAP_SHIR;
      TAP_UIR:  nxt_state = tms_i ? TAP_SDR  : TAP_RTI;
      default:  nxt_state = TAP_TLR;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= TAP_TLR;
    end else if (clr_i) begin
      state_ff <= TAP_TLR;
    end else if (adv_i) begin
      state_ff <= nxt_state;
    end
  end

  assign state_o = state_ff;

endmodule

/* File: design/spcc_fifo.sv */
`timescale 1ns/1ps
// Small word buffer; a full buffer drops in_ready so no word is lost.
module spcc_fifo
  import spcc_pkg::*;
#(
  parameter int W     = ADDR_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         flush_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_ff [DEPTH];
  logic [IW-1:0] wr_idx_ff;
  logic [IW-1:0] rd_idx_ff;
  logic [CW-1:0] cnt_ff;
  logic          push;
  logic          pop;

  assign in_ready_o  = (cnt_ff != CW'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o  = mem_ff[rd_idx_ff];
  assign push        = in_valid_i & in_ready_o & ~flush_i;
  assign pop         = out_valid_o & out_ready_i & ~flush_i;

  for (genvar g = 0; g < DEPTH; g++) begin : g_entry
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        mem_ff[g] <= '0;
      end else if (push && wr_idx_ff == IW'(g)) begin
        mem_ff[g] <= in_data_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_idx_ff <= '0;
      rd_idx_ff <= '0;
      cnt_ff    <= '0;
    end else if (flush_i) begin
      wr_idx_ff <= '0;
      rd_idx_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (push) begin
        wr_idx_ff <= (wr_idx_ff == IW'(DEPTH - 1)) ? '0 : wr_idx_ff + 1'b1;
      end
      if (pop) begin
        rd_idx_ff <= (rd_idx_ff == IW'(DEPTH - 1)) ? '0 : rd_idx_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

endmodule

/* File: test/spcc_master.sv */
`timescale 1ns/1ps
// Backplane test master; the test clock stands still outside its cycles.
module spcc_master (
  input  wire logic clk_i,
  output logic      tck_o,
  output logic      tdi_o,
  output logic      tms_o
);
  initial begin
    tck_o = 1'b0;
    tdi_o = 1'b1;
    tms_o = 1'b0;
  end

  task automatic lvl(input logic ms, input logic di);
    @(negedge clk_i);
    tms_o = ms;
    tdi_o = di;
  endtask

  // One 90 ns test clock period, data set up well before the rise.
  task automatic cyc(input logic ms, input logic di);
    lvl(ms, di);
    repeat (4) @(negedge clk_i);
    tck_o = 1'b1;
    repeat (4) @(negedge clk_i);
    tck_o = 1'b0;
  endtask

  // Start bit low, then ten address bits least significant first.
  task automatic frame(input logic [9:0] a, input logic ms, input logic bad);
    cyc(ms, 1'b0);
    for (int i = 0; i < 10; i++) begin
      cyc((bad && i >= 5) ? ~ms : ms, a[i]);
    end
    lvl(ms, 1'b1);
  endtask

  // Data-in stays high, so no new select can form during an acknowledge.
  task automatic idle(input int n, input logic ms);
    for (int i = 0; i < n; i++) begin
      cyc(ms, 1'b1);
    end
  endtask
endmodule

/* File: test/spcc_top_bench.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s expected %b seen %b", n, e, g); end end
module spcc_top_bench
  import spcc_pkg::*;
;
  localparam logic [ADDR_W-1:0] BOARD = 10'h2A5;
  logic clk;
  logic rstn;
  logic trst_n;
  logic sdi;
  logic byp_n;
  logic uo;
  logic uoe;
  logic dso;
  logic dsoe;
  logic downstream_mode_select;
  logic downstream_test_clock;
  logic downstream_test_reset_n;
  logic link_n;
  wire  tck;
  wire  tdi;
  wire  tms;
  int   failures = 0;
  int   checks = 0;

  spcc_top uut (
    .MCLK_I                   (clk),
    .RSTN_I                   (rstn),
    .UPSTREAM_TEST_CLOCK_I    (tck),
    .UPSTREAM_DATA_IN_I       (tdi),
    .UPSTREAM_MODE_SELECT_I   (tms),
    .UPSTREAM_TEST_RESET_N_I  (trst_n),
    .DOWNSTREAM_DATA_IN_I     (sdi),
    .FORCE_THROUGH_N_I        (byp_n),
    .BOARD_ADDRESS_PINS_I     (BOARD),
    .UPSTREAM_DATA_OUT_O      (uo),
    .UPSTREAM_DATA_OUT_OE_O   (uoe),
    .DOWNSTREAM_DATA_OUT_O    (dso),
    .DOWNSTREAM_DATA_OUT_OE_O (dsoe),
    .DOWNSTREAM_MODE_SELECT_O (downstream_mode_select),
    .DOWNSTREAM_TEST_CLOCK_O  (downstream_test_clock),
    .DOWNSTREAM_TEST_RESET_N_O(downstream_test_reset_n),
    .LINK_ACTIVE_N_O          (link_n)
  );

  spcc_master master (.clk_i(clk), .tck_o(tck), .tdi_o(tdi), .tms_o(tms));

  always #5 clk = ~clk;

  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic look(input logic eu, input logic ed, input logic el);
    w(8);
    `CHK("up_oe", eu, uoe)
    `CHK("dn_oe", ed, dsoe)
    `CHK("link_n", el, link_n)
  endtask

  task automatic match();
    master.frame(BOARD, 1'b0, 1'b0);
    master.idle(10, 1'b0);
    w(8);
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic t_match();
    master.frame(BOARD, 1'b0, 1'b0);
    look(1'b1, 1'b0, 1'b1);
    master.idle(10, 1'b0);
    look(1'b1, 1'b1, 1'b0);
    sdi = 1'b1;
    master.lvl(1'b0, 1'b0);
    w(8);
    `CHK("dn_data", 1'b0, dso)
    `CHK("up_data", 1'b1, uo)
    `CHK("dn_ms", 1'b0, downstream_mode_select)
    $display("match done");
  endtask

  task automatic t_nosync();
    master.frame(ADDR_SYNC, 1'b0, 1'b0);
    look(1'b0, 1'b0, 1'b1);
    $display("sync outside pause done");
  endtask

  task automatic t_globals();
    match();
    master.frame(ADDR_DROP, 1'b0, 1'b0);
    look(1'b0, 1'b0, 1'b1);
    `CHK("dn_ms", 1'b0, downstream_mode_select)
    match();
    master.frame(10'h155, 1'b0, 1'b0);
    look(1'b0, 1'b0, 1'b1);
    match();
    master.frame(ADDR_RESTART, 1'b0, 1'b0);
    look(1'b0, 1'b0, 1'b1);
    `CHK("dn_ms", 1'b1, downstream_mode_select)
    $display("global addresses done");
  endtask

  // While connected, the primary TAP and the secondary TAP both walk from Run-Test/Idle to Pause-DR.
  task automatic t_sync();
    match();
    for (int i = 0; i < 5; i++) master.idle(1, i[0]);
    master.frame(ADDR_SYNC, 1'b0, 1'b0);
    look(1'b0, 1'b1, 1'b0);
    master.lvl(1'b0, 1'b0);
    w(8);
    `CHK("dn_data", 1'b0, dso)
    `CHK("dn_ms", 1'b0, downstream_mode_select)
    $display("group sync done");
  endtask

  task automatic t_trst();
    trst_n = 1'b0;
    #1 `CHK("downstream_test_reset_n", 1'b0, downstream_test_reset_n)
    look(1'b0, 1'b0, 1'b1);
    `CHK("dn_ms", 1'b1, downstream_mode_select)
    master.frame(BOARD, 1'b0, 1'b0);
    trst_n = 1'b1;
    #1 `CHK("downstream_test_reset_n", 1'b1, downstream_test_reset_n)
    look(1'b0, 1'b0, 1'b1);
    $display("test reset done");
  endtask

  task automatic t_hard();
    match();
    master.frame(BOARD, 1'b0, 1'b1);
    look(1'b0, 1'b0, 1'b1);
    // The cut frame can leave a stale start behind; one steady rise clears it.
    master.idle(1, 1'b0);
    $display("hard error done");
  endtask

  // Bypass is entered from ON so that its release must bring ON back.
  task automatic t_byp();
    match();
    byp_n = 1'b0;
    look(1'b1, 1'b1, 1'b0);
    sdi = 1'b0;
    fork
      master.cyc(1'b1, 1'b1);
      begin
        w(8);
        `CHK("downstream_test_clock", 1'b1, downstream_test_clock)
      end
    join
    `CHK("dn_data", 1'b1, dso)
    `CHK("up_data", 1'b0, uo)
    `CHK("dn_ms", 1'b1, downstream_mode_select)
    master.lvl(1'b0, 1'b0);
    w(8);
    `CHK("dn_ms", 1'b0, downstream_mode_select)
    `CHK("dn_data", 1'b0, dso)
    byp_n = 1'b1;
    look(1'b1, 1'b1, 1'b0);
    byp_n = 1'b0;
    trst_n = 1'b0;
    look(1'b1, 1'b1, 1'b0);
    `CHK("dn_ms", 1'b1, downstream_mode_select)
    trst_n = 1'b1;
    master.frame(BOARD, 1'b0, 1'b0);
    byp_n = 1'b1;
    look(1'b0, 1'b0, 1'b1);
    $display("bypass done");
  endtask

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    trst_n = 1'b1;
    sdi = 1'b0;
    byp_n = 1'b1;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    w(4);
    t_match();
    t_nosync();
    t_globals();
    t_sync();
    t_trst();
    t_hard();
    t_byp();
    conclude();
  end

  // The tests take about 24 us; give them ample margin.
  initial begin
    #400000;
    failures++;
    conclude();
  end
endmodule
